// file: inc/ochs_consts.vh
`ifndef OCHS_CONSTS_VH
`define OCHS_CONSTS_VH

// Clock period of the control logic in ns
`define OCHS_CLK_NS          10
// Free-running switching period in ns (set by the timing resistor)
`define OCHS_FREE_RUN_NS     200
// Free-running period in clock cycles, a longest time so rounded down
`define OCHS_FREE_RUN_CYC    (`OCHS_FREE_RUN_NS / `OCHS_CLK_NS)
// Sync is dropped after this many ns without a rising edge
`define OCHS_SYNC_LOSS_NS    400
`define OCHS_SYNC_LOSS_CYC   (`OCHS_SYNC_LOSS_NS / `OCHS_CLK_NS)
// Last oscillator and sync-watch counts, one below the cycle counts above
`define OCHS_OSC_LAST        8'h13
`define OCHS_SYNC_LAST       8'h27
// Overcurrent fault counter limit that starts hiccup
`define OCHS_FAULT_LIMIT     3'h7
// Number of qualifying cycles before undervoltage changes state
`define OCHS_UV_LIMIT        3'h7
// Reset values
`define OCHS_FAULT_RST       3'h0
`define OCHS_UV_RST          3'h0
`define OCHS_TIMER_RST       8'h00

`endif

// file: verilog/ochs_sync2.v
`timescale 1ns/1ps
module ochs_sync2 #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst,
  // Asynchronous input and its synchronised copy
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1;

  // Two-flop synchroniser; stage1 feeds only syncOut
  always @(posedge clk)
  begin
    if (rst)
    begin
      stage1  <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule // ochs_sync2

// file: verilog/ochs_ctrl.v
// Behaviour
// RULE1: Overcurrent compare only counts while high-side drive is on.
// RULE2: Overcurrent ends the high-side pulse immediately, ahead of the modulator.
// RULE3: After overcurrent, high side stays off until next cycle starts.
// RULE4: Fault counter up per overcurrent cycle, down per clean cycle.
// RULE5: Counter at seven issues restart and seven soft-start cycles (hiccup).
// RULE6: Hiccup holds both high-side and low-side drives off.
// RULE7: Each completed soft-start cycle in hiccup decrements the counter.
// RULE8: Counter at zero ends hiccup and re-enables modulation.
// RULE9: With external sync, each cycle begins on sync rising edge.
// RULE10: Active sync replaces internal oscillator as cycle timing source.
// RULE11: Sync held low lets the internal oscillator run freely.
// RULE12: Sync source should run 20% to 30% above free-run frequency.
// RULE13: A clock edge cutting the ramp short flags undervoltage, disables modulation.
// RULE14: Cycle is short if clock arrives before ramp reaches 90%.
// RULE15: Undervoltage declared only after seven short cycles accumulate.
// RULE16: Fault counter saturates at zero in normal operation.
`timescale 1ns/1ps
`include "ochs_consts.vh"
module ochs_ctrl (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // External sync pin, sampled on clk
  input  wire       syncPin,
  // Analog comparators and modulator, all asynchronous
  input  wire       overcurrentTrip,
  input  wire       modulatorEnd,
  input  wire       rampAt90,
  input  wire       softStartDone,
  // Switch drives
  output reg        highSideDrive,
  output reg        lowSideRectifierSwitch,
  // Status
  output reg        cycleStart,
  output reg        syncActive,
  output reg        hiccupActive,
  output reg        softStartRestart,
  output reg        undervoltageLockout,
  output reg  [2:0] faultCount
);

  wire [4:0] syncd;
  wire       syncLevel;
  wire       ocLevel;
  wire       modEndLevel;
  wire       rampLevel;
  wire       ssLevel;

  reg        syncPrev;
  reg        ssPrev;
  reg  [7:0] oscTimer;
  reg  [7:0] syncTimer;
  reg        ocSeen;
  reg        rampSeen;
  reg  [2:0] uvCount;

  reg        next_cycleStart;
  reg        next_high;
  reg        next_ocSeen;
  reg  [2:0] next_faultCount;
  reg        next_hiccup;
  reg        next_restart;
  reg  [2:0] next_uvCount;
  reg        next_undervoltage_lockout;

  wire       syncRise;
  wire       ssRise;
  wire       oscWrap;
  wire       runEnable;

  // All analog and pin inputs cross into clk through two flops
  ochs_sync2 #(
    .WIDTH   (5)
  ) u_sync (
    .clk     (clk),
    .rst     (rst),
    .asyncIn ({syncPin, overcurrentTrip, modulatorEnd, rampAt90, softStartDone}),
    .syncOut (syncd)
  );

  assign syncLevel   = syncd[4];
  assign ocLevel     = syncd[3];
  assign modEndLevel = syncd[2];
  assign rampLevel   = syncd[1];
  assign ssLevel     = syncd[0];

  // Edge detectors work on synchronised levels only
  assign syncRise  = syncLevel & ~syncPrev;
  assign ssRise    = ssLevel & ~ssPrev;
  // At-or-above so free-run picks up at once after sync is lost
  assign oscWrap   = (oscTimer >= `OCHS_OSC_LAST);
  assign runEnable = ~hiccupActive & ~undervoltageLockout;

  // Oscillator and sync detection; a missing edge times out to free-run
  always @(posedge clk)
  begin
    if (rst)
    begin
      syncPrev   <= 1'b0;
      ssPrev     <= 1'b0;
      oscTimer   <= `OCHS_TIMER_RST;
      syncTimer  <= `OCHS_TIMER_RST;
      syncActive <= 1'b0;
    end
    else
    begin
      syncPrev <= syncLevel;
      ssPrev   <= ssLevel;
      // Oscillator restarts on any cycle start so it never fires mid-sync period
      if (next_cycleStart)
        oscTimer <= `OCHS_TIMER_RST;
      else
        oscTimer <= oscTimer + 8'h01;
      if (syncRise)
      begin
        syncTimer  <= `OCHS_TIMER_RST;
        syncActive <= 1'b1;                                // [RULE10]
      end
      else if (syncTimer == `OCHS_SYNC_LAST)
        syncActive <= 1'b0;                                // [RULE11]
      else
        syncTimer <= syncTimer + 8'h01;
    end
  end

  // Cycle start source select
  always @*
  begin
    if (syncActive)
      next_cycleStart = syncRise;                          // [RULE9] [RULE10]
    else
      next_cycleStart = syncRise | oscWrap;                // [RULE11]
  end

  // High-side pulse, overcurrent latch and fault counter
  always @*
  begin
    next_high       = highSideDrive;
    next_ocSeen     = ocSeen;
    next_faultCount = faultCount;
    next_hiccup     = hiccupActive;
    next_restart    = 1'b0;
    if (hiccupActive)
    begin
      next_high   = 1'b0;                                  // [RULE6]
      next_ocSeen = 1'b0;
      if (ssRise)
      begin
        next_faultCount = faultCount - 3'h1;               // [RULE7]
        if (faultCount == 3'h1)
          next_hiccup = 1'b0;                              // [RULE8]
        else
          next_restart = 1'b1;
      end
    end
    else if (next_cycleStart)
    begin
      // Close out the finished cycle, then open the new one
      if (ocSeen)
      begin
        next_faultCount = faultCount + 3'h1;               // [RULE4]
        if (faultCount == `OCHS_FAULT_LIMIT - 3'h1)
        begin
          next_hiccup  = 1'b1;                             // [RULE5]
          next_restart = 1'b1;                             // [RULE5]
        end
      end
      else if (faultCount != 3'h0)
        next_faultCount = faultCount - 3'h1;               // [RULE4] [RULE16]
      next_ocSeen = 1'b0;
      next_high   = runEnable & ~next_hiccup;              // [RULE3]
    end
    else if (highSideDrive & ocLevel)
    begin
      next_high   = 1'b0;                                  // [RULE1] [RULE2]
      next_ocSeen = 1'b1;                                  // [RULE3]
    end
    else if (highSideDrive & modEndLevel)
      next_high = 1'b0;
    // Next lockout state, so no pulse opens in the cycle lockout begins
    if (next_undervoltage_lockout)
      next_high = 1'b0;                                    // [RULE13]
  end

  // Ramp qualification filter; sync edges that cut the ramp count as short
  always @*
  begin
    next_uvCount = uvCount;
    next_undervoltage_lockout    = undervoltageLockout;
    if (next_cycleStart)
    begin
      if (undervoltageLockout == rampSeen)
      begin
        // Cycle argues for a change of state
        if (uvCount == `OCHS_UV_LIMIT - 3'h1)
        begin
          next_undervoltage_lockout    = ~undervoltageLockout;             // [RULE13] [RULE15]
          next_uvCount = `OCHS_UV_RST;
        end
        else
          next_uvCount = uvCount + 3'h1;                   // [RULE14] [RULE15]
      end
      else if (uvCount != 3'h0)
        next_uvCount = uvCount - 3'h1;                     // [RULE15]
    end
  end

  // State registers; outputs all leave from flops
  always @(posedge clk)
  begin
    if (rst)
    begin
      cycleStart             <= 1'b0;
      highSideDrive          <= 1'b0;
      lowSideRectifierSwitch <= 1'b0;
      ocSeen                 <= 1'b0;
      faultCount             <= `OCHS_FAULT_RST;
      hiccupActive           <= 1'b0;
      softStartRestart       <= 1'b0;
      rampSeen               <= 1'b0;
      uvCount                <= `OCHS_UV_RST;
      undervoltageLockout    <= 1'b1;  // Held off until ramp proves supply
    end
    else
    begin
      cycleStart       <= next_cycleStart;
      highSideDrive    <= next_high;
      ocSeen           <= next_ocSeen;
      faultCount       <= next_faultCount;
      hiccupActive     <= next_hiccup;
      softStartRestart <= next_restart;
      uvCount          <= next_uvCount;
      undervoltageLockout <= next_undervoltage_lockout;
      // Ramp reach is tracked per cycle
      if (next_cycleStart)
        rampSeen <= 1'b0;
      else if (rampLevel)
        rampSeen <= 1'b1;                                  // [RULE14]
      // Low side only after high side was already off: no cross conduction
      lowSideRectifierSwitch <= ~next_high & ~highSideDrive & ~next_hiccup
                                & ~next_undervoltage_lockout;              // [RULE6] [RULE13]
    end
  end

endmodule // ochs_ctrl

// file: tb/ochs_ctrl_chk.sv
`timescale 1ns/1ps
module ochs_ctrl_chk (
  // Clock and reset
  input wire       clk,
  input wire       rst,
  // Watched ports
  input wire       syncPin,
  input wire       overcurrentTrip,
  input wire       highSideDrive,
  input wire       lowSideRectifierSwitch,
  input wire       cycleStart,
  input wire       syncActive,
  input wire       hiccupActive,
  input wire       softStartRestart,
  input wire       undervoltageLockout,
  input wire [2:0] faultCount
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Pulse limiter and restart point
  a_oc_cut: assert property (highSideDrive && overcurrentTrip |-> ##[1:4] !highSideDrive) else $error("no cut");
  a_resume_at_start: assert property ($rose(highSideDrive) |-> cycleStart) else $error("early on");
  // Fault counter moves by one, no wrap below zero
  a_count_step: assert property (!$stable(faultCount) |-> (faultCount - $past(faultCount)) inside {3'h1, 3'h7})
    else $error("bad step");
  a_no_wrap: assert property ($past(faultCount) == 3'h0 && !hiccupActive |-> faultCount != 3'h7) else $error("wrap");
  // Hiccup entry, hold and count down
  a_hiccup_entry: assert property ($rose(hiccupActive) |-> faultCount == 3'h7 && softStartRestart) else $error("entry");
  a_hiccup_off: assert property (hiccupActive && $past(hiccupActive) |-> !highSideDrive && !lowSideRectifierSwitch)
    else $error("drive on");
  a_hiccup_dec: assert property ($past(hiccupActive) && !$stable(faultCount) |-> $past(faultCount) - faultCount == 3'h1)
    else $error("no dec");
  a_hiccup_exit: assert property ($fell(hiccupActive) |-> faultCount == 3'h0) else $error("exit");
  // Cycle timing sources and undervoltage drive-off
  a_sync_start: assert property (syncActive && $rose(syncPin) |-> ##[3:5] cycleStart) else $error("sync");
  a_free_run: assert property (cycleStart && !syncActive |-> ##[1:21] cycleStart) else $error("osc");
  a_uv_off: assert property (undervoltageLockout |-> !highSideDrive) else $error("uv");
  a_sync_loss: assert property ($fell(syncActive) |-> ##[1:2] cycleStart) else $error("no free run");
  c_hiccup: cover property ($rose(hiccupActive));
  c_sync: cover property ($rose(syncActive));
  c_uv: cover property ($rose(undervoltageLockout));
endmodule // ochs_ctrl_chk

bind ochs_ctrl ochs_ctrl_chk ochs_ctrl_chk_i (
  .clk                    (clk),
  .rst                    (rst),
  .syncPin                (syncPin),
  .overcurrentTrip        (overcurrentTrip),
  .highSideDrive          (highSideDrive),
  .lowSideRectifierSwitch (lowSideRectifierSwitch),
  .cycleStart             (cycleStart),
  .syncActive             (syncActive),
  .hiccupActive           (hiccupActive),
  .softStartRestart       (softStartRestart),
  .undervoltageLockout    (undervoltageLockout),
  .faultCount             (faultCount)
);

// file: tb/ochs_partner.sv
`timescale 1ns/1ps
module ochs_partner (
  // Bench controls
  input  wire overload,
  input  wire syncOn,
  // Device side
  input  wire highSideDrive,
  output reg  syncPin,
  output wire overcurrentTrip
);
  // Switch drop only exists while the switch conducts
  assign overcurrentTrip = overload & highSideDrive;
  // Sync 25% above free run, odd phase; held low when off
  initial
  begin
    syncPin = 1'b0;
    #3;
    forever
    begin
      #80;
      syncPin = syncOn & ~syncPin;
    end
  end
endmodule // ochs_partner

// file: tb/ochs_ctrl_test.sv
`timescale 1ns/1ps
module ochs_ctrl_test;
  reg        clk;
  reg        rst;
  reg        overload;
  reg        syncOn;
  reg        modulatorEnd;
  reg        rampAt90;
  reg        softStartDone;
  wire       syncPin, overcurrentTrip, highSideDrive, lowSideRectifierSwitch;
  wire       cycleStart, syncActive, hiccupActive, softStartRestart, undervoltageLockout;
  wire [2:0] faultCount;
  integer    errors = 0;
  integer    num_checks = 0;
  integer    cycles = 0;
  integer    seed = 32'hD8F9EC29;
  integer    phase = 0;
  integer    lim = 8;
  integer    i;
  reg  [5:0] notes[$];
  reg  [5:0] seen = 6'h10;

  ochs_ctrl ochs_ctrl_i (
    .clk                    (clk),
    .rst                    (rst),
    .syncPin                (syncPin),
    .overcurrentTrip        (overcurrentTrip),
    .modulatorEnd           (modulatorEnd),
    .rampAt90               (rampAt90),
    .softStartDone          (softStartDone),
    .highSideDrive          (highSideDrive),
    .lowSideRectifierSwitch (lowSideRectifierSwitch),
    .cycleStart             (cycleStart),
    .syncActive             (syncActive),
    .hiccupActive           (hiccupActive),
    .softStartRestart       (softStartRestart),
    .undervoltageLockout    (undervoltageLockout),
    .faultCount             (faultCount)
  );
  ochs_partner ochs_partner_i (
    .overload               (overload),
    .syncOn                 (syncOn),
    .highSideDrive          (highSideDrive),
    .syncPin                (syncPin),
    .overcurrentTrip        (overcurrentTrip)
  );

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Modulator ends each pulse a random time into the cycle
  // Short window: a level still high at the next start would cut that pulse
  always @(negedge clk)
  begin
    phase = cycleStart ? 0 : phase + 1;
    if (phase == 1)
      lim = 2 + ($random(seed) & 7);
    modulatorEnd <= (phase > lim) && (phase < lim + 3);
  end

  // Hang guard
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 6000)
    begin
      errors = errors + 1;
      $display("mismatch cycles exp below 6000 got %0d", cycles);
      end_sim;
    end
  end

  // Every status change must match the oldest note
  always @(posedge clk)
  begin
    #1;
    if (!rst && {syncActive, undervoltageLockout, hiccupActive, faultCount} !== seen)
    begin
      seen = {syncActive, undervoltageLockout, hiccupActive, faultCount};
      cmp(seen);
    end
  end

  task cmp(input [5:0] got);
    reg [5:0] exp;
  begin
    exp = notes.size() ? notes.pop_front() : 6'h3F;
    num_checks = num_checks + 1;
    if (exp !== got)
    begin
      errors = errors + 1;
      $display("mismatch status exp %h got %h", exp, got);
    end
  end
  endtask

  task end_sim;
  begin
    if (errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask

  // Main sequence, notes pushed as each phase is driven
  initial
  begin
    rst           = 1'b1;
    overload      = 1'b0;
    syncOn        = 1'b0;
    rampAt90      = 1'b1;
    softStartDone = 1'b0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    notes.push_back(6'h00);
    wait (!undervoltageLockout);
    @(negedge clk);
    // Two overload cycles, then clean cycles walk the counter back to zero
    notes.push_back(6'h01);
    notes.push_back(6'h02);
    notes.push_back(6'h01);
    notes.push_back(6'h00);
    overload = 1'b1;
    wait (faultCount == 3'h2);
    @(negedge clk);
    overload = 1'b0;
    wait (faultCount == 3'h0);
    @(negedge clk);
    for (i = 1; i < 7; i = i + 1)
      notes.push_back(i[5:0]);
    notes.push_back(6'h0F);
    overload = 1'b1;
    wait (hiccupActive);
    @(negedge clk);
    overload = 1'b0;
    for (i = 6; i > 0; i = i + -1)
      notes.push_back(6'h08 + i[5:0]);
    notes.push_back(6'h00);
    repeat (7)
    begin
      repeat (5 + ($random(seed) & 15)) @(negedge clk);
      softStartDone = 1'b1;
      repeat (4) @(negedge clk);
      softStartDone = 1'b0;
    end
    // Clean cycles must leave the counter at zero
    repeat (100) @(negedge clk);
    notes.push_back(6'h20);
    syncOn = 1'b1;
    wait (syncActive);
    repeat (40) @(negedge clk);
    notes.push_back(6'h30);
    rampAt90 = 1'b0;
    wait (undervoltageLockout);
    @(negedge clk);
    notes.push_back(6'h10);
    syncOn = 1'b0;
    wait (!syncActive);
    @(negedge clk);
    notes.push_back(6'h00);
    rampAt90 = 1'b1;
    wait (!undervoltageLockout);
    repeat (50) @(negedge clk);
    if (notes.size() != 0)
    begin
      errors = errors + 1;
      $display("mismatch notes exp 0 got %0d", notes.size());
    end
    end_sim;
  end
endmodule // ochs_ctrl_test
